// ===== bench/flash_cmd_checker.sv
// concurrent checks on the pins of the status command decoder
// assumes one clk_i domain and protect inputs held steady by the host
`timescale 1ns/1ps
module flash_cmd_checker
	import flash_cmd_pkg::*;
#(
	parameter int         TW_CYC    = TW_CYCLES,
	parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEF
) (
	input wire logic        clk_i,            // system clock
	input wire logic        sys_rst_i,        // async reset
	input wire logic        cs_n_i,           // select, active low
	input wire logic        sclk_i,           // serial clock
	input wire logic        serial_in_i,      // serial data in
	input wire logic        wp_n_i,           // write protect, low active
	input wire logic        serial_out_o,     // serial data out
	input wire logic        serial_out_oe_o,  // data out enable
	input wire logic [7:0]  status_o,         // status image
	input wire logic        mem_start_o,      // launch pulse
	input wire logic [7:0]  mem_opcode_o,     // launched opcode
	input wire logic [23:0] mem_addr_o,       // launched address
	input wire logic        addr_protected_i, // address protected
	input wire logic        mem_done_i        // program/erase done
);
	// ***************************************************
	// busy run length and its origin
	// ***************************************************
	logic [31:0] run_reg; // consecutive busy cycles
	logic        mem_reg; // busy came from a launch
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run_reg <= 32'h0;
			mem_reg <= 1'b0;
		end else begin
			run_reg <= status_o[0] ? run_reg + 32'h1 : 32'h0;
			mem_reg <= mem_start_o | (mem_reg & status_o[0]);
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_reserved_bit_zero:
	assert property (status_o[6] == 1'b0) else $error("reserved status bit set");
	a_latch_set_frame:
	assert property ($rose(status_o[1]) |-> cs_n_i) else $error("latch set inside frame");
	a_prot_bits_frame:
	assert property ($changed(status_o[7:2]) |-> cs_n_i && status_o[1])
		else $error("status bits changed outside commit");
	a_lock_blocks_write:
	assert property ($changed(status_o[7:2]) |-> !($past(status_o[7]) && !wp_n_i))
		else $error("locked status written");
	a_launch_needs_wel:
	assert property (mem_start_o |-> $past(status_o[1]) && !$past(status_o[0]))
		else $error("launch without latch or while busy");
	a_launch_unprotected:
	assert property (mem_start_o |-> !$past(addr_protected_i))
		else $error("protected area launched");
	a_latch_clear_done:
	assert property (mem_done_i && mem_reg |-> ##[1:3] !status_o[1])
		else $error("latch kept after completion");
	a_write_cycle_len:
	assert property ($fell(status_o[0]) && !mem_reg |-> run_reg inside {[TW_CYC-1:TW_CYC+2]})
		else $error("write cycle length wrong");
	a_oe_off_idle:
	assert property (cs_n_i [*6] |-> !serial_out_oe_o) else $error("output driven while idle");
	a_out_on_fall:
	assert property ($changed(serial_out_o) && serial_out_oe_o |-> !$past(sclk_i, 2))
		else $error("output changed off falling edge");
endmodule
bind flash_cmd_ctrl flash_cmd_checker #(.TW_CYC(TW_CYC), .DEVICE_ID(DEVICE_ID)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
	.serial_in_i(serial_in_i), .wp_n_i(wp_n_i), .serial_out_o(serial_out_o),
	.serial_out_oe_o(serial_out_oe_o), .status_o(status_o), .mem_start_o(mem_start_o),
	.mem_opcode_o(mem_opcode_o), .mem_addr_o(mem_addr_o),
	.addr_protected_i(addr_protected_i), .mem_done_i(mem_done_i));

// ===== bench/spi_host_model.sv
// serial host that frames commands for the status decoder
// assumes mode 0 timing paced by the bench clock, 200 ns per bit
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk_i,     // pacing clock
	input  wire logic miso_i,    // device data out
	input  wire logic miso_oe_i, // device drive enable
	output logic      cs_n_o,    // select, active low
	output logic      sclk_o,    // serial clock
	output logic      mosi_o     // data to device
);
	logic miso_last = 1'b0; // last value the device drove
	logic miso_line;        // level seen on the wire
	// a released wire reads as the inverse of its last driven value
	assign miso_line = miso_oe_i ? miso_i : ~miso_last;
	always @(posedge clk_i) begin
		if (miso_oe_i)
			miso_last <= miso_i;
	end
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// one frame: nbits sent, reply bits shifted in at the end of each high phase
	task automatic frame(input logic [63:0] tx, input int nbits,
		output logic [63:0] rx, output logic oe_any);
		rx = 64'h0;
		oe_any = 1'b0;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi_o = tx[63 - i];
			sclk_o = 1'b0;
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			rx = {rx[62:0], miso_line};
			oe_any = oe_any | miso_oe_i;
		end
		sclk_o = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		repeat (8) @(negedge clk_i);
	endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the flash status command decoder
// assumes the host model frames commands; program/erase ends by hand
`timescale 1ns/1ps
module testbench
	import flash_cmd_pkg::*;
;
	// ***************************************************
	// signals
	// ***************************************************
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wp_n_i = 1'b1;
	logic        addr_protected_i = 1'b0;
	logic        mem_done_i = 1'b0;
	logic        cs_n, sclk, mosi, sout, sout_oe, mem_start_o, oe_v;
	logic [7:0]  status_o, mem_opcode_o, last_opc;
	logic [23:0] mem_addr_o, last_addr;
	logic [63:0] rx_v;
	int          err_total = 0, n_tests = 0, cyc = 0, starts = 0;
	always #12.5 clk_i = ~clk_i;
	flash_cmd_ctrl #(.TW_CYC(400)) u_flash_cmd_ctrl (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.serial_in_i(mosi), .wp_n_i(wp_n_i), .serial_out_o(sout),
		.serial_out_oe_o(sout_oe), .status_o(status_o), .mem_start_o(mem_start_o),
		.mem_opcode_o(mem_opcode_o), .mem_addr_o(mem_addr_o),
		.addr_protected_i(addr_protected_i), .mem_done_i(mem_done_i));
	spi_host_model u_spi_host_model (.clk_i(clk_i), .miso_i(sout), .miso_oe_i(sout_oe),
		.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
	// launch monitor and run limit
	always @(negedge clk_i) begin
		cyc++;
		if (mem_start_o === 1'b1) begin
			starts++;
			last_opc = mem_opcode_o;
			last_addr = mem_addr_o;
		end
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end
	// ***************************************************
	// shared tasks
	// ***************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [63:0] tx, input int nbits);
		u_spi_host_model.frame(tx, nbits, rx_v, oe_v);
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 2000 && status_o[0] !== 1'b0; k++)
			@(negedge clk_i);
		// the latch clear trails the end of busy; let it settle
		repeat (2) @(negedge clk_i);
		chk(status_o[0], 1'b0);
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_reset();
		chk({status_o, mem_opcode_o, 7'h0, sout_oe, 7'h0, mem_start_o}, 32'h0);
		chk(mem_addr_o, 32'h0);
	endtask
	task automatic t_latch();
		send({OPC_WREN, 56'h0}, 8);
		chk(status_o, 8'h02);
		send({OPC_RDSR, 56'h0}, 24);
		chk({oe_v, rx_v[15:0]}, 17'h10202);
		send({OPC_WRDI, 56'h0}, 8);
		chk(status_o, 8'h00);
	endtask
	task automatic t_wrsr();
		send({OPC_WRSR, 8'hff, 48'h0}, 16);
		chk(status_o, 8'h00);
		send({OPC_WREN, 56'h0}, 8);
		send({OPC_WRSR, 8'hff, 48'h0}, 16);
		send({OPC_RDSR, 56'h0}, 24);
		chk(rx_v[15:0], 16'hbfbf);
		wait_idle();
		chk(status_o, 8'hbc);
	endtask
	task automatic t_busy();
		send({OPC_WREN, 56'h0}, 8);
		send({OPC_WRSR, 8'h80, 48'h0}, 16);
		send({OPC_IDENT, 56'h0}, 24);
		chk(oe_v, 1'b0);
		send({OPC_WREN, 56'h0}, 8);
		wait_idle();
		chk(status_o, 8'h80);
	endtask
	task automatic t_lock();
		wp_n_i = 1'b0;
		send({OPC_WREN, 56'h0}, 8);
		send({OPC_WRSR, 8'h00, 48'h0}, 16);
		chk(status_o, 8'h82);
		wp_n_i = 1'b1;
		send({OPC_WRSR, 8'h00, 48'h0}, 16);
		wait_idle();
		chk(status_o, 8'h00);
	endtask
	task automatic t_partial();
		send({OPC_WREN, 56'h0}, 8);
		send({OPC_WRSR, 8'h9c, 48'h0}, 12);
		chk(status_o, 8'h02);
		send({OPC_WRDI, 56'h0}, 8);
	endtask
	task automatic t_ident();
		send({OPC_IDENT, 56'h0}, 48);
		chk(rx_v[15:0], {DEVICE_ID_DEF, DEVICE_ID_DEF});
		send({8'h9f, 56'h0}, 24);
		chk({oe_v, status_o}, 9'h000);
	endtask
	task automatic t_mem();
		logic [7:0] opc [4] = '{OPC_PROG, OPC_SERA, OPC_BERA, OPC_CERA};
		int         nb [4] = '{40, 32, 32, 8};
		int         s;
		for (int i = 0; i < 4; i++) begin
			s = starts;
			send({OPC_WREN, 56'h0}, 8);
			send({opc[i], 24'h0a0b0c, 32'h0}, nb[i]);
			chk({starts - s}, 32'h1);
			chk({last_opc, status_o}, {opc[i], 8'h03});
			if (i < 3)
				chk(last_addr, 32'h0a0b0c);
			mem_done_i = 1'b1;
			@(negedge clk_i);
			mem_done_i = 1'b0;
			repeat (4) @(negedge clk_i);
			chk(status_o, 8'h00);
		end
		s = starts;
		send({OPC_PROG, 24'h0a0b0c, 32'h0}, 40);
		send({OPC_WREN, 56'h0}, 8);
		addr_protected_i = 1'b1;
		send({OPC_SERA, 24'h0a0b0c, 32'h0}, 32);
		addr_protected_i = 1'b0;
		chk({starts - s}, 32'h0);
		send({OPC_WRDI, 56'h0}, 8);
	endtask
	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		t_reset();
		t_latch();
		t_wrsr();
		t_busy();
		t_lock();
		t_partial();
		t_ident();
		t_mem();
		final_report();
	end
endmodule

// ===== hw/flash_cmd_ctrl.sv
// status, write enable and framing logic of a serial flash
// assumes the link pins are asynchronous and far slower than clk_i;
// program and erase bodies and the address map live outside
`timescale 1ns/1ps
module flash_cmd_ctrl
	import flash_cmd_pkg::*;
#(
	parameter int         TW_CYC    = TW_CYCLES,
	parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEF
) (
	input  wire logic        clk_i,            // system clock
	input  wire logic        sys_rst_i,        // async reset, active high
	input  wire logic        cs_n_i,           // select, active low
	input  wire logic        sclk_i,           // serial clock from host
	input  wire logic        serial_in_i,      // serial data in
	input  wire logic        wp_n_i,           // write protect, active low
	output logic             serial_out_o,     // serial data out
	output logic             serial_out_oe_o,  // drive enable of data out
	output logic [7:0]       status_o,         // status byte image
	output logic             mem_start_o,      // program/erase launch pulse
	output logic [7:0]       mem_opcode_o,     // launched opcode
	output logic [23:0]      mem_addr_o,       // launched address
	input  wire logic        addr_protected_i, // mem_addr_o is protected
	input  wire logic        mem_done_i        // program/erase finished
);

	// ***************************************************
	// pin synchronisers
	// ***************************************************
	pins_t      pins_raw;
	pins_t      s;
	logic [3:0] s_vec;

	// gather the raw pins in struct order
	assign pins_raw = '{cs_n: cs_n_i, sclk: sclk_i, sdi: serial_in_i, wp_n: wp_n_i};

	// every pin is asynchronous, so nothing reads it before two flops;
	// the reset image holds select high so no false frame starts
	flash_sync #(
		.W   (4),
		.RST (PINS_RST)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       (pins_raw),
		.q_o       (s_vec)
	);

	// view the synchronised bits as named pins
	assign s = pins_t'(s_vec);

	// ***************************************************
	// status write timer
	// ***************************************************
	// decoder state, current and next
	cmd_regs_t q;
	cmd_regs_t n;
	logic      tw_busy;
	logic      tw_done;

	// timer runs the write cycle; its start comes from a register
	flash_wr_timer #(
		.CYC (TW_CYC)
	) u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (q.tw_start),
		.busy_o    (tw_busy),
		.done_o    (tw_done)
	);

	// ***************************************************
	// edges and status image
	// ***************************************************
	logic       busy;
	logic       cs_fall;
	logic       cs_rise;
	logic       clk_rise;
	logic       clk_fall;
	logic [7:0] status;

	// busy merges both cycle sources; edges compare the synced pins with
	// last cycle's copy, three clocks after the pin moves, so every link
	// phase must last at least three system clocks
	assign busy     = tw_busy | q.mem_busy;
	assign cs_fall  = !s.cs_n && q.prev.cs_n;
	assign cs_rise  = s.cs_n && !q.prev.cs_n;
	assign clk_rise = s.sclk && !q.prev.sclk;
	assign clk_fall = !s.sclk && q.prev.sclk;

	// status byte, reserved bit reads zero
	always_comb begin
		status                = 8'h00;
		status[SR_LOCK_POS]   = q.lock;
		status[SR_TOP_POS]    = q.top_bottom_select;
		status[SR_BP_HI:SR_BP_LO] = q.bp;
		status[SR_LATCH_POS]  = q.write_enable_latch;
		status[SR_BUSY_POS]   = busy;
	end

	// ***************************************************
	// command decoder
	// ***************************************************
	// decoder helpers
	logic [7:0] sh_in;
	logic       byte_done;
	logic [7:0] out_byte;
	logic       may_write;
	logic       wr_ok;

	assign sh_in     = {q.sh[6:0], s.sdi};
	assign byte_done = (q.bitcnt == 3'h7);
	assign may_write = q.write_enable_latch;
	assign wr_ok     = may_write && !(q.lock && !s.wp_n);

	// next state of the whole decoder, one pass per clock
	always_comb begin
		n           = q;
		n.prev      = s;
		// status image is registered so the output leaves a flip-flop
		n.stat      = status;
		n.mem_start = 1'b0;
		n.tw_start  = 1'b0;
		out_byte    = q.tx;

		if (tw_done || mem_done_i) begin
			n.write_enable_latch = 1'b0;
			n.mem_busy = q.mem_busy && !mem_done_i;
		end

		if (cs_fall) begin
			n.st     = ST_OPC;
			n.bitcnt = 3'h0;
			n.args   = 3'h0;
			n.ocnt   = 3'h0;
			n.oe     = 1'b0;
		end else if (!s.cs_n) begin
			if (clk_rise) begin
				n.sh     = sh_in;
				n.bitcnt = q.bitcnt + 3'h1;
				unique case (q.st)
					ST_OPC: begin
						if (byte_done) begin
							n.opc = sh_in;
							if (sh_in == OPC_RDSR) begin
								// read-status always taken
								// oe rises now so the first falling edge finds the line driven
								n.st   = ST_STAT;
								n.oe   = 1'b1;
								n.ocnt = 3'h0;
							end else if (busy) begin
								n.st = ST_SKIP;
							end else begin
								unique case (sh_in)
									OPC_WREN, OPC_WRDI, OPC_WRSR,
									OPC_PROG, OPC_SERA, OPC_BERA,
									OPC_CERA, OPC_IDENT: begin
										n.st = ST_ARGS;
									end
									default: begin
										n.st = ST_SKIP;
									end
								endcase
							end
						end
					end
					ST_ARGS: begin
						// the first three argument bytes form the address; the first
						// one is also the status write data
						if (byte_done) begin
							if (q.args < ADDR_BYTES) begin
								n.addr = {q.addr[15:0], sh_in};
							end
							if (q.args == 3'h0) begin
								n.wdat = sh_in;
							end
							if (q.args != ARGS_MAX) begin
								n.args = q.args + 3'h1;
							end
							if (q.opc == OPC_IDENT && q.args == IDENT_LAST) begin
								n.st   = ST_ID;
								n.oe   = 1'b1;
								n.ocnt = 3'h0;
							end
						end
					end
					ST_STAT, ST_ID, ST_SKIP: begin
						// these states wait for select to rise
					end
					default: begin
						n.st = ST_SKIP;
					end
				endcase
			end

			// the output side runs off falling link edges only
			if (clk_fall && (q.st == ST_STAT || q.st == ST_ID)) begin
				if (q.ocnt == 3'h0) begin
					out_byte = (q.st == ST_STAT) ? status : DEVICE_ID;
				end
				n.obit = out_byte[7];
				n.tx   = {out_byte[6:0], 1'b0};
				n.ocnt = q.ocnt + 3'h1;
			end
		end

		// commands commit only when select rises, so a host can still
		// abort any write by raising select in mid-byte
		if (cs_rise) begin
			n.st = ST_OPC;
			n.oe = 1'b0;
			if (q.st == ST_ARGS && q.bitcnt == 3'h0) begin
				unique case (q.opc)
					OPC_WREN: begin
						n.write_enable_latch = 1'b1;
					end
					OPC_WRDI: begin
						n.write_enable_latch = 1'b0;
					end
					OPC_WRSR: begin
						// opcode and data byte
						// a locked or unlatched write is dropped silently
						if (q.args >= WRSR_BYTES && wr_ok) begin
							n.lock     = q.wdat[SR_LOCK_POS];
							n.top_bottom_select = q.wdat[SR_TOP_POS];
							n.bp       = q.wdat[SR_BP_HI:SR_BP_LO];
							n.tw_start = 1'b1;
						end
					end
					OPC_PROG: begin
						if (q.args >= PROG_BYTES && may_write && !addr_protected_i) begin
							n.mem_start = 1'b1;
							n.mem_busy  = 1'b1;
						end
					end
					OPC_SERA, OPC_BERA: begin
						if (q.args >= ADDR_BYTES && may_write && !addr_protected_i) begin
							n.mem_start = 1'b1;
							n.mem_busy  = 1'b1;
						end
					end
					OPC_CERA: begin
						if (may_write && q.bp == 3'h0) begin
							n.mem_start = 1'b1;
							n.mem_busy  = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ***************************************************
	// state register
	// ***************************************************
	// one register holds all decoder state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q           <= '0;
			q.prev      <= pins_t'(PINS_RST);
			q.st        <= ST_OPC;
			q.lock      <= LOCK_RST;
			q.top_bottom_select  <= TOP_RST;
			q.bp        <= BP_RST;
			q.write_enable_latch <= LATCH_RST;
		end else begin
			q <= n;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	// every output leaves a register; the status image trails the
	// state it shows by one clock
	assign serial_out_o    = q.obit;
	assign serial_out_oe_o = q.oe;
	assign status_o        = q.stat;
	assign mem_start_o     = q.mem_start;
	assign mem_opcode_o    = q.opc;
	assign mem_addr_o      = q.addr;

endmodule

// ===== hw/flash_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs that are asynchronous to clk_i
`timescale 1ns/1ps
module flash_sync #(
	parameter int              W   = 4,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk_i,     // system clock
	input  wire logic         sys_rst_i, // async reset, active high
	input  wire logic [W-1:0] d_i,       // raw pins
	output logic      [W-1:0] q_o        // synchronised pins
);

	logic [2*W-1:0] st_reg;
	logic [2*W-1:0] st_next;

	// first stage feeds only the second stage
	always_comb begin
		st_next = {st_reg[W-1:0], d_i};
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= {RST, RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg[2*W-1:W];

endmodule

// ===== hw/flash_wr_timer.sv
// self-timed status write cycle counter
// assumes start_i is a one-cycle pulse that only comes while idle
`timescale 1ns/1ps
module flash_wr_timer
	import flash_cmd_pkg::*;
#(
	parameter int CYC = TW_CYCLES
) (
	input  wire logic clk_i,     // system clock
	input  wire logic sys_rst_i, // async reset, active high
	input  wire logic start_i,   // begin a write cycle
	output logic      busy_o,    // cycle running
	output logic      done_o     // one-cycle end pulse
);

	timer_t t_reg;
	timer_t t_next;

	// count down from start until the last cycle
	always_comb begin
		t_next      = t_reg;
		t_next.done = 1'b0;
		if (start_i && !t_reg.busy) begin
			t_next.busy = 1'b1;
			t_next.cnt  = 32'(CYC - 1);
		end else if (t_reg.busy) begin
			if (t_reg.cnt == 32'h0) begin
				t_next.busy = 1'b0;
				t_next.done = 1'b1;
			end else begin
				t_next.cnt = t_reg.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign busy_o = t_reg.busy;
	assign done_o = t_reg.done;

endmodule

// ===== inc/flash_cmd_pkg.sv
// constants, state types and carriers of the flash status command decoder
// assumes a 40 MHz system clock that oversamples the serial link pins
//
// Overview of operation
// - write-enable opcode sets the write enable latch.
// - program, erase and status writes are refused unless the latch is set.
// - write-disable opcode, framed by select, clears the latch.
// - latch clears at reset and when any write, program or erase completes.
// - opcode bits sampled on rising clock; commands act when select rises.
// - read-status drives eight status bits, msb first, on falling edges.
// - status byte repeats, freshly taken, until select goes high.
// - read-status is accepted at any time, also while busy.
// - status write is opcode plus one data byte, needs the latch set.
// - status write changes only bits 7, 5, 4, 3 and 2.
// - status write is dropped unless select rises on a byte boundary.
// - valid status write runs a timed cycle with busy high throughout.
// - with lock bit set, status writes are refused while protect pin low.
// - range bits protect memory; protected program or erase is refused.
// - all bytes travel msb first; read data leaves on the serial output.
// - identifier command repeats the device identifier until select rises.
// - falling select starts a command; the first byte is the opcode.
// - while busy, every opcode except read-status is ignored.
package flash_cmd_pkg;

	// ***************************************************
	// opcodes
	// ***************************************************
	localparam logic [7:0] OPC_WREN  = 8'h06;
	localparam logic [7:0] OPC_WRDI  = 8'h04;
	localparam logic [7:0] OPC_RDSR  = 8'h05;
	localparam logic [7:0] OPC_WRSR  = 8'h01;
	localparam logic [7:0] OPC_PROG  = 8'h02;
	localparam logic [7:0] OPC_SERA  = 8'h20;
	localparam logic [7:0] OPC_BERA  = 8'hd8;
	localparam logic [7:0] OPC_CERA  = 8'hc7;
	localparam logic [7:0] OPC_IDENT = 8'hab;

	// ***************************************************
	// status byte layout and reset values
	// ***************************************************
	localparam int         SR_LOCK_POS = 7;
	localparam int         SR_TOP_POS  = 5;
	localparam int         SR_BP_HI    = 4;
	localparam int         SR_BP_LO    = 2;
	localparam int         SR_LATCH_POS = 1;
	localparam int         SR_BUSY_POS = 0;
	localparam logic       LOCK_RST    = 1'b0;
	localparam logic       TOP_RST     = 1'b0;
	localparam logic [2:0] BP_RST      = 3'h0;
	localparam logic       LATCH_RST   = 1'b0;

	// ***************************************************
	// argument byte counts
	// ***************************************************
	localparam logic [2:0] WRSR_BYTES  = 3'h1;
	localparam logic [2:0] ADDR_BYTES  = 3'h3;
	localparam logic [2:0] PROG_BYTES  = 3'h4;
	localparam logic [2:0] ARGS_MAX    = 3'h7;
	localparam logic [2:0] IDENT_LAST  = 3'h2; // index of the last dummy byte

	// identifier value is arbitrary
	localparam logic [7:0] DEVICE_ID_DEF = 8'h5a;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int TW_NS     = 10000000; // status write cycle, ns
	localparam int CLK_NS    = 25;
	localparam int TW_CYCLES = (TW_NS + CLK_NS - 1) / CLK_NS;

	// synchroniser reset image: select high, clock low, data low, protect high
	localparam logic [3:0] PINS_RST = 4'h9;

	// ***************************************************
	// types
	// ***************************************************
	typedef enum logic [2:0] {
		ST_OPC  = 3'b000,
		ST_ARGS = 3'b001,
		ST_STAT = 3'b010,
		ST_ID   = 3'b011,
		ST_SKIP = 3'b100
	} cmd_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
		logic wp_n;
	} pins_t;

	typedef struct packed {
		logic        busy;
		logic [31:0] cnt;
		logic        done;
	} timer_t;

	typedef struct packed {
		pins_t       prev;
		cmd_state_t  st;
		logic [7:0]  sh;
		logic [2:0]  bitcnt;
		logic [2:0]  ocnt;
		logic [2:0]  args;
		logic [7:0]  opc;
		logic [23:0] addr;
		logic [7:0]  wdat;
		logic [7:0]  tx;
		logic        obit;
		logic        oe;
		logic        lock;
		logic        top_bottom_select;
		logic [2:0]  bp;
		logic        write_enable_latch;
		logic        mem_busy;
		logic        mem_start;
		logic        tw_start;
		logic [7:0]  stat;
	} cmd_regs_t;

endpackage
